/* File: pkg/pfm_pkg.sv */
// Shared constants of the phase fault manager.
package pfm_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned LATCH_MS = 14;
    // Fault latch length in cycles: 14 ms at the system clock rate.
    localparam int unsigned LATCH_CYC = CLK_HZ / 1000 * LATCH_MS;
    localparam int unsigned LATCH_W = 20;
    localparam int unsigned PROP_NS = 180;
    localparam int unsigned PROP_CYC = (PROP_NS * 40 + 999) / 1000;
    localparam int unsigned BLANK_NS = 1050;
    localparam int unsigned BLANK_CYC = (BLANK_NS * 40 + 999) / 1000;
    localparam int unsigned SHORT_W = 8;
    localparam int unsigned NPHASE = 3;
    localparam logic [1:0] GATE_OFF = 2'h0;
    localparam logic [1:0] GATE_ON = 2'h1;
    localparam logic [1:0] GATE_SOFT = 2'h2;
endpackage

/* File: pkg/pfm_gate_if.sv */
// Interface carrying one switching path between phase logic and its channel.
`timescale 1ns/100ps
`default_nettype none
interface pfm_gate_if;
    logic cmd;
    logic block;
    logic drain_sense;
    logic sec_fault;
    logic fault_latched;
    logic [1:0] gate;
    modport phase (output cmd, output block, output drain_sense,
        output sec_fault, input fault_latched, input gate);
    modport chan (input cmd, input block, input drain_sense,
        input sec_fault, output fault_latched, output gate);
endinterface
`default_nettype wire

/* File: core/pfm_latch.sv */
// Fault latch timer: holds a fault for the latch time and while it lasts.
`timescale 1ns/100ps
`default_nettype none
module pfm_latch
    import pfm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cause,
    output logic active
);
    logic [LATCH_W-1:0] cnt_q, cnt_d;
    logic act_q, act_d;

    always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (cause && !act_q) begin
            act_d = 1'b1;
            cnt_d = LATCH_W'(LATCH_CYC - 1);
        end else if (act_q) begin
            if (cnt_q != '0) begin
                cnt_d = cnt_q - 1'b1;
            end else if (!cause) begin
                act_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            act_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end

    assign active = act_q;
endmodule
`default_nettype wire

/* File: core/pfm_channel.sv */
// One gate channel: delay, blanking, desaturation check, secondary latch.
`timescale 1ns/100ps
`default_nettype none
module pfm_channel
    import pfm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    pfm_gate_if.chan gi
);
    typedef enum logic [3:0] {
        S_OFF = 4'h1, S_DLY = 4'h2, S_ON = 4'h4, S_SOFT = 4'h8
    } pfm_gst_e;
    pfm_gst_e st_q, st_d;
    logic [SHORT_W-1:0] cnt_q, cnt_d;
    logic [1:0] gate_q, gate_d;
    logic cmd_q, desat_q, desat_d;
    logic lat_act, cause, rise;

    assign cause = gi.sec_fault | desat_q;
    assign rise = gi.cmd & ~cmd_q;

    pfm_latch u_lat (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cause(cause),
        .active(lat_act)
    );

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        gate_d = gate_q;
        desat_d = 1'b0;
        unique case (st_q)
            S_OFF: begin
                gate_d = GATE_OFF;
                if (rise && !lat_act && !gi.block) begin // [R6] [R10]
                    st_d = S_DLY;
                    cnt_d = SHORT_W'(PROP_CYC - 1);
                end
            end
            S_DLY: begin
                if (gate_q == GATE_ON) begin
                    // Falling delay: the gate stays on until the count ends or a fault forces soft shutdown.
                    if (gi.sec_fault || lat_act) begin
                        st_d = S_SOFT; // [R9]
                        gate_d = GATE_SOFT;
                    end else if (cnt_q != '0) begin
                        cnt_d = cnt_q - 1'b1;
                    end else begin
                        st_d = S_OFF; // [R14]
                        gate_d = GATE_OFF;
                    end
                end else if (lat_act || gi.block || !gi.cmd) begin
                    st_d = S_OFF;
                end else if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    st_d = S_ON; // [R14]
                    gate_d = GATE_ON;
                    cnt_d = SHORT_W'(BLANK_CYC);
                end
            end
            S_ON: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1; // [R15]
                end
                if (gi.sec_fault || lat_act
                    || (cnt_q == '0 && gi.drain_sense)) begin
                    st_d = S_SOFT; // [R9] [R16] [R17]
                    gate_d = GATE_SOFT;
                    desat_d = cnt_q == '0 && gi.drain_sense; // [R16]
                end else if (gi.block || !gi.cmd) begin
                    st_d = S_DLY; // [R14]
                    cnt_d = SHORT_W'(PROP_CYC - 1);
                end
            end
            S_SOFT: begin
                gate_d = GATE_SOFT; // [R8]
                if (!lat_act && !cause) begin
                    st_d = S_OFF;
                    gate_d = GATE_OFF;
                end
            end
            default: begin
                st_d = S_OFF;
                gate_d = GATE_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= S_OFF;
            cnt_q <= '0;
            gate_q <= GATE_OFF;
            cmd_q <= 1'b0;
            desat_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            gate_q <= gate_d;
            cmd_q <= gi.cmd;
            desat_q <= desat_d;
        end
    end

    assign gi.gate = gate_q;
    assign gi.fault_latched = lat_act | cause; // [R8]
endmodule
`default_nettype wire

/* File: core/pfm_top.sv */
// Three-phase fault supervision top with per-phase fault aggregation.
//
// How it works
// [R1] Each phase has its own fault logic; nothing is shared across phases.
// [R2] Supply undervoltage or logic regulator not good forms one primary fault.
// [R3] The primary fault is held for 14 ms even if its cause leaves.
// [R4] While primary fault held: faults low, both gates off, converter off.
// [R5] After the hold, a present cause keeps the phase in fault.
// [R6] When primary clears, converter back on; paths wait for rising command.
// [R7] A secondary fault is undervoltage, regulator not good, or desaturation.
// [R8] A secondary fault is held 14 ms with its gate kept off.
// [R9] Entering secondary fault turns the gate off through soft shutdown.
// [R10] After the hold, gate off while cause lasts; resume on rising command.
// [R11] Per-side mode: bottom on primary or low fault, top on primary or high.
// [R12] Per-phase mode: one output low on any fault, released otherwise.
// [R13] Inhibit low forces every command to zero, all gates off.
// [R14] Gate follows command edges after a propagation delay.
// [R15] Drain sense is ignored until the blanking time after turn-on.
// [R16] Drain high after blanking: soft off, fault low, cleared by timer.
// [R17] Secondary undervoltage: soft off, fault low, cleared by timer.
// [R18] Low and high commands of a phase are never active together.
// [R19] Missing secondary supply is reported as a primary fault.
// [R20] Controller drives commands active high unless active-low is chosen.
// [R21] The latch time is a cycle count derived from the clock rate.
//
// Gate codes per phase: 0 off, 1 on, 2 soft shutdown.
`timescale 1ns/100ps
`default_nettype none
module pfm_top
    import pfm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic per_phase_mode,
    input wire logic cmd_active_low,
    input wire logic drive_inhibit_n,
    input wire logic [NPHASE-1:0] low_side_cmd,
    input wire logic [NPHASE-1:0] high_side_cmd,
    input wire logic [NPHASE-1:0] vcc_supply_low_lockout,
    input wire logic [NPHASE-1:0] logic_reg_not_good,
    input wire logic [NPHASE-1:0] low_supply_low_lockout,
    input wire logic [NPHASE-1:0] low_reg_not_good,
    input wire logic [NPHASE-1:0] low_supply_absent,
    input wire logic [NPHASE-1:0] low_drain_sense,
    input wire logic [NPHASE-1:0] high_supply_low_lockout,
    input wire logic [NPHASE-1:0] high_reg_not_good,
    input wire logic [NPHASE-1:0] high_supply_absent,
    input wire logic [NPHASE-1:0] high_drain_sense,
    output logic [2*NPHASE-1:0] low_gate,
    output logic [2*NPHASE-1:0] high_gate,
    output logic [NPHASE-1:0] converter_en,
    output logic [NPHASE-1:0] bottom_fault_out_n,
    output logic [NPHASE-1:0] bottom_fault_oe,
    output logic [NPHASE-1:0] top_fault_out_n,
    output logic [NPHASE-1:0] top_fault_oe,
    output logic [NPHASE-1:0] phase_fault_out_n,
    output logic [NPHASE-1:0] phase_fault_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: all pin inputs pass two flip-flops.
    localparam int unsigned SW = 3 + 12 * NPHASE;
    logic [SW-1:0] raw, s1_q, s2_q;
    assign raw = {per_phase_mode, cmd_active_low, drive_inhibit_n,
        low_side_cmd, high_side_cmd, vcc_supply_low_lockout,
        logic_reg_not_good, low_supply_low_lockout, low_reg_not_good,
        low_supply_absent, low_drain_sense, high_supply_low_lockout,
        high_reg_not_good, high_supply_absent, high_drain_sense};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    logic mode_s, alow_s, inh_n_s;
    logic [NPHASE-1:0] lc_s, hc_s, vuv_s, lng_s, luv_s, lrg_s, lab_s;
    logic [NPHASE-1:0] lds_s, huv_s, hrg_s, hab_s, hds_s;
    assign mode_s = s2_q[SW-1];
    assign alow_s = s2_q[SW-2];
    assign inh_n_s = s2_q[SW-3];
    assign {lc_s, hc_s, vuv_s, lng_s, luv_s, lrg_s, lab_s, lds_s,
        huv_s, hrg_s, hab_s, hds_s} = s2_q[12*NPHASE-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Per-phase supervision.
    logic [2*NPHASE-1:0] lg_d, hg_d;
    logic [NPHASE-1:0] conv_d, bot_d, top_d, ph_d;

    for (genvar p = 0; p < NPHASE; p++) begin : g_ph // [R1]
        pfm_gate_if lo_if ();
        pfm_gate_if hi_if ();
        logic prim_cause, prim_act, lc, hc;

        // Missing secondary supply counts as a primary cause.
        assign prim_cause = vuv_s[p] | lng_s[p]
            | lab_s[p] | hab_s[p]; // [R2] [R19]

        pfm_latch u_prim (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .cause(prim_cause),
            .active(prim_act)
        ); // [R3] [R5] [R21]

        // Polarity, inhibit and anti-overlap on the incoming commands.
        always_comb begin
            lc = (lc_s[p] ^ alow_s) & inh_n_s; // [R13] [R20]
            hc = (hc_s[p] ^ alow_s) & inh_n_s; // [R13] [R20]
            if (lc && hc) begin
                lc = 1'b0; // [R18]
                hc = 1'b0;
            end
        end

        assign lo_if.cmd = lc;
        assign hi_if.cmd = hc;
        assign lo_if.block = prim_act | ~inh_n_s; // [R4] [R6]
        assign hi_if.block = prim_act | ~inh_n_s; // [R4] [R6]
        assign lo_if.drain_sense = lds_s[p];
        assign hi_if.drain_sense = hds_s[p];
        assign lo_if.sec_fault = luv_s[p] | lrg_s[p]; // [R7]
        assign hi_if.sec_fault = huv_s[p] | hrg_s[p]; // [R7]

        pfm_channel u_lo (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .gi(lo_if.chan)
        );
        pfm_channel u_hi (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .gi(hi_if.chan)
        );

        always_comb begin
            lg_d[2*p +: 2] = prim_act ? GATE_OFF : lo_if.gate; // [R4]
            hg_d[2*p +: 2] = prim_act ? GATE_OFF : hi_if.gate; // [R4]
            conv_d[p] = ~prim_act; // [R4] [R6]
            bot_d[p] = prim_act | lo_if.fault_latched; // [R11]
            top_d[p] = prim_act | hi_if.fault_latched; // [R11]
            ph_d[p] = prim_act | lo_if.fault_latched
                | hi_if.fault_latched; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs; open-drain pins only ever drive low.
    logic [2*NPHASE-1:0] lg_q, hg_q;
    logic [NPHASE-1:0] conv_q, bot_q, top_q, ph_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lg_q <= '0;
            hg_q <= '0;
            conv_q <= '0;
            bot_q <= '0;
            top_q <= '0;
            ph_q <= '0;
        end else begin
            lg_q <= lg_d;
            hg_q <= hg_d;
            conv_q <= conv_d;
            bot_q <= bot_d & {NPHASE{~mode_s}}; // [R11]
            top_q <= top_d & {NPHASE{~mode_s}}; // [R11]
            ph_q <= ph_d & {NPHASE{mode_s}}; // [R12]
        end
    end

    assign low_gate = lg_q;
    assign high_gate = hg_q;
    assign converter_en = conv_q;
    assign bottom_fault_out_n = '0;
    assign top_fault_out_n = '0;
    assign phase_fault_out_n = '0;
    assign bottom_fault_oe = bot_q;
    assign top_fault_oe = top_q;
    assign phase_fault_oe = ph_q;
endmodule
`default_nettype wire

/* File: dv/pfm_top_asserts.sv */
// Concurrent checks on the ports of the phase fault manager top.
`timescale 1ns/100ps
`default_nettype none
module pfm_top_asserts
    import pfm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic per_phase_mode,
    input wire logic drive_inhibit_n,
    input wire logic [NPHASE-1:0] vcc_supply_low_lockout,
    input wire logic [NPHASE-1:0] logic_reg_not_good,
    input wire logic [NPHASE-1:0] low_drain_sense,
    input wire logic [2*NPHASE-1:0] low_gate,
    input wire logic [2*NPHASE-1:0] high_gate,
    input wire logic [NPHASE-1:0] converter_en,
    input wire logic [NPHASE-1:0] bottom_fault_oe,
    input wire logic [NPHASE-1:0] top_fault_oe,
    input wire logic [NPHASE-1:0] phase_fault_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Counters of phase 0 low side on and soft cycles, and of inhibit cycles.
    logic [7:0] on_q, on_d;
    logic [7:0] inh_q, inh_d;
    logic [LATCH_W-1:0] soft_q, soft_d;
    always_comb begin
        on_d = 8'h00;
        soft_d = '0;
        inh_d = 8'h00;
        if (!sys_rst && !drive_inhibit_n) begin
            inh_d = (inh_q == 8'hFF) ? inh_q : inh_q + 8'h01;
        end
        if (!sys_rst && low_gate[1:0] == GATE_ON) begin
            on_d = (on_q == 8'hFF) ? on_q : on_q + 8'h01;
        end
        if (!sys_rst && low_gate[1:0] == GATE_SOFT) begin
            soft_d = soft_q + 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        on_q <= on_d;
        soft_q <= soft_d;
        inh_q <= inh_d;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_prim_side_pins: assert property ($rose(vcc_supply_low_lockout[0])
        && !per_phase_mode |-> ##[2:6] (bottom_fault_oe[0] && top_fault_oe[0]))
        else $error("primary fault did not pull both side outputs");
    chk_prim_gates_off: assert property ($rose(vcc_supply_low_lockout[0])
        |-> ##[2:6] (low_gate[1:0] == GATE_OFF && high_gate[1:0] == GATE_OFF
        && !converter_en[0])) else $error("primary fault left drive running");
    chk_reg_phase_pin: assert property ($rose(logic_reg_not_good[1])
        && per_phase_mode |-> ##[2:6] phase_fault_oe[1])
        else $error("regulator fault did not pull phase output");
    chk_no_overlap: assert property (!(low_gate[1:0] == GATE_ON
        && high_gate[1:0] == GATE_ON)) else $error("both gates of phase on");
    chk_inhibit_off: assert property (inh_q >= 8'h0E
        |-> low_gate[1:0] != GATE_ON) else $error("gate on while inhibited");
    chk_blank_wait: assert property (low_gate[1:0] == GATE_ON
        && on_q < 8'h1E |=> low_gate[1:0] != GATE_SOFT)
        else $error("soft shutdown inside blanking time");
    chk_desat_soft: assert property (low_gate[1:0] == GATE_ON
        && low_drain_sense[0] && on_q >= 8'h26 |-> ##[1:10]
        low_gate[1:0] == GATE_SOFT) else $error("desaturation not acted on");
    chk_desat_flag: assert property ($rose(low_gate[1:0] == GATE_SOFT)
        && !per_phase_mode |-> ##[0:3] bottom_fault_oe[0])
        else $error("soft shutdown without bottom fault output");
    chk_soft_hold: assert property ($fell(low_gate[1:0] == GATE_SOFT)
        |-> soft_q >= LATCH_CYC - 4) else $error("fault latch ended early");
endmodule
bind pfm_top pfm_top_asserts u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .per_phase_mode(per_phase_mode), .drive_inhibit_n(drive_inhibit_n),
    .vcc_supply_low_lockout(vcc_supply_low_lockout),
    .logic_reg_not_good(logic_reg_not_good),
    .low_drain_sense(low_drain_sense), .low_gate(low_gate),
    .high_gate(high_gate), .converter_en(converter_en),
    .bottom_fault_oe(bottom_fault_oe), .top_fault_oe(top_fault_oe),
    .phase_fault_oe(phase_fault_oe));
`default_nettype wire

/* File: dv/pfm_ctrl_model.sv */
// Controller and power stage stand-in facing the phase fault manager.
`timescale 1ns/100ps
`default_nettype none
module pfm_ctrl_model
    import pfm_pkg::*;
(
    input wire logic inhibit_req,
    input wire logic active_low,
    input wire logic [NPHASE-1:0] low_req,
    input wire logic [NPHASE-1:0] high_req,
    input wire logic [NPHASE-1:0] low_short,
    input wire logic [2*NPHASE-1:0] low_gate,
    input wire logic [2*NPHASE-1:0] high_gate,
    input wire logic [NPHASE-1:0] bottom_fault_oe,
    input wire logic [NPHASE-1:0] top_fault_oe,
    input wire logic [NPHASE-1:0] phase_fault_oe,
    output logic drive_inhibit_n,
    output logic [NPHASE-1:0] low_side_cmd,
    output logic [NPHASE-1:0] high_side_cmd,
    output logic [NPHASE-1:0] low_drain_sense,
    output logic [NPHASE-1:0] high_drain_sense,
    output logic [NPHASE-1:0] bot_pin,
    output logic [NPHASE-1:0] top_pin,
    output logic [NPHASE-1:0] ph_pin
);
    assign drive_inhibit_n = !inhibit_req;
    assign low_side_cmd = low_req ^ {NPHASE{active_low}};
    assign high_side_cmd = high_req ^ {NPHASE{active_low}};
    // Fault pins are pulled up and sink low only while the driver is enabled.
    assign bot_pin = ~bottom_fault_oe;
    assign top_pin = ~top_fault_oe;
    assign ph_pin = ~phase_fault_oe;
    // An open switch leaves its drain high; a shorted one stays high when on.
    always_comb begin
        for (int p = 0; p < NPHASE; p++) begin
            low_drain_sense[p] = (low_gate[2*p+:2] == GATE_ON)
                ? low_short[p] : 1'b1;
            high_drain_sense[p] = (high_gate[2*p+:2] != GATE_ON);
        end
    end
endmodule
`default_nettype wire

/* File: dv/phase_fault_manager_tb.sv */
// Self-checking bench for the phase fault manager top.
`timescale 1ns/100ps
`default_nettype none
module phase_fault_manager_tb import pfm_pkg::*;;
    logic sys_clk, sys_rst, mode, inh_n, inhibit_req, alow;
    logic [2:0] low_req, high_req, low_short, lcmd, hcmd, lds, hds, conv;
    logic [2:0] boe, toe, poe, bot_pin, top_pin, ph_pin, bon, ton, pon;
    logic [2:0] cause [8];
    logic [5:0] low_gate, high_gate;
    // Row fields: mode, cause source, phase, bottom, top, converter.
    logic [8:0] rows [11] = '{9'h006, 9'h02E, 9'h055, 9'h065, 9'h08E, 9'h0B3,
        9'h0C3, 9'h0F6, 9'h155, 9'h1C5, 9'h12C};
    int failures = 0, comparisons = 0, p, q;
    pfm_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .per_phase_mode(mode),
        .cmd_active_low(alow), .drive_inhibit_n(inh_n), .low_side_cmd(lcmd),
        .high_side_cmd(hcmd), .vcc_supply_low_lockout(cause[0]),
        .logic_reg_not_good(cause[1]), .low_supply_low_lockout(cause[2]),
        .low_reg_not_good(cause[3]), .low_supply_absent(cause[4]),
        .low_drain_sense(lds), .high_supply_low_lockout(cause[5]),
        .high_reg_not_good(cause[6]), .high_supply_absent(cause[7]),
        .high_drain_sense(hds), .low_gate(low_gate), .high_gate(high_gate),
        .converter_en(conv), .bottom_fault_out_n(bon), .bottom_fault_oe(boe),
        .top_fault_out_n(ton), .top_fault_oe(toe), .phase_fault_out_n(pon),
        .phase_fault_oe(poe));
    pfm_ctrl_model u_ctrl (.inhibit_req(inhibit_req), .active_low(alow),
        .low_req(low_req),
        .high_req(high_req), .low_short(low_short), .low_gate(low_gate),
        .high_gate(high_gate), .bottom_fault_oe(boe), .top_fault_oe(toe),
        .phase_fault_oe(poe), .drive_inhibit_n(inh_n), .low_side_cmd(lcmd),
        .high_side_cmd(hcmd), .low_drain_sense(lds), .high_drain_sense(hds),
        .bot_pin(bot_pin), .top_pin(top_pin), .ph_pin(ph_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic start();
        foreach (cause[i]) cause[i] = 3'h0;
        {inhibit_req, low_req, high_req, low_short} = 10'h000;
        sys_rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        conclude();
    end
    initial begin
        mode = 1'b0;
        alow = 1'b0;
        foreach (rows[i]) begin
            mode = rows[i][8];
            start();
            p = rows[i][4:3];
            q = (p == 2) ? 0 : p + 1;
            chk("idle_pin", 2'h1, {1'b0, mode ? ph_pin[p] : bot_pin[p] & top_pin[p]});
            chk("idle_conv", 2'h1, {1'b0, conv[p]});
            chk("pull_value", 2'h0, {1'b0, |{bon, ton, pon}});
            cause[rows[i][7:5]][p] = 1'b1;
            wait_n(10);
            if (mode) begin
                chk("phase_pin", {1'b0, !rows[i][2]}, {1'b0, ph_pin[p]});
            end else begin
                chk("bottom_pin", {1'b0, !rows[i][2]}, {1'b0, bot_pin[p]});
                chk("top_pin", {1'b0, !rows[i][1]}, {1'b0, top_pin[p]});
            end
            chk("converter", {1'b0, rows[i][0]}, {1'b0, conv[p]});
            chk("other_conv", 2'h1, {1'b0, conv[q]});
        end
        // Normal switching, then a drain fault on the low side of phase 0.
        mode = 1'b0;
        start();
        low_req[0] = 1'b1;
        wait_n(20);
        chk("gate_on", GATE_ON, low_gate[1:0]);
        wait_n(60);
        chk("no_desat", 2'h1, {1'b0, bot_pin[0]});
        low_req[0] = 1'b0;
        wait_n(20);
        chk("gate_off", GATE_OFF, low_gate[1:0]);
        low_short[0] = 1'b1;
        low_req[0] = 1'b1;
        wait_n(30);
        chk("blanked", GATE_ON, low_gate[1:0]);
        wait_n(40);
        chk("soft_off", GATE_SOFT, low_gate[1:0]);
        chk("desat_pin", 2'h0, {1'b0, bot_pin[0]});
        {low_req[0], low_short[0]} = 2'h0;
        wait_n(20);
        low_req[0] = 1'b1;
        wait_n(20);
        chk("latched", GATE_SOFT, low_gate[1:0]);
        // Secondary undervoltage while the low gate is on, commands active low.
        alow = 1'b1;
        start();
        low_req[0] = 1'b1;
        wait_n(80);
        chk("alow_on", GATE_ON, low_gate[1:0]);
        cause[2][0] = 1'b1;
        wait_n(10);
        chk("supply_low_lockout_soft", GATE_SOFT, low_gate[1:0]);
        chk("supply_low_lockout_pin", 2'h0, {1'b0, bot_pin[0]});
        // Inhibit a running gate and a new command, then overlapping commands.
        alow = 1'b0;
        start();
        low_req[0] = 1'b1;
        wait_n(20);
        inhibit_req = 1'b1;
        low_req[1] = 1'b1;
        high_req[1] = 1'b0;
        wait_n(30);
        chk("inhibit_run", GATE_OFF, low_gate[1:0]);
        chk("inhibited", GATE_OFF, low_gate[3:2]);
        inhibit_req = 1'b0;
        {low_req[2], high_req[2]} = 2'h3;
        wait_n(30);
        chk("released", GATE_ON, low_gate[3:2]);
        chk("overlap_low", GATE_OFF, low_gate[5:4]);
        chk("overlap_high", GATE_OFF, high_gate[5:4]);
        conclude();
    end
endmodule
`default_nettype wire
